// [hdl/quad_dac_host_ctrl.sv]
/*
 Host end: classic Wishbone slave with control, command and status
 registers, and a sequencer that drives the serial link.
 Assumes a 50 MHz clock; the link clock is divided from it.
*/
`timescale 1ns/1ns
module quad_dac_host_ctrl
#(
	parameter int HALF_CYC = dac_link_pkg::SCLK_HALF_CYC,
	parameter int STROBE_CYC = dac_link_pkg::STROBE_LOW_CYC
)
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic [3:0] ADR_I,
	input wire logic [31:0] DAT_I,
	input wire logic [3:0] SEL_I,
	input wire logic WE_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	serial_link_if.host LINK
);
	import dac_link_pkg::*;

	localparam int CNT_W = $clog2(HALF_CYC + STROBE_CYC + 1);

	// Sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_HIGH, ST_LOW, ST_GAP, ST_LOAD, ST_UPDATE} state_t;

	state_t state_reg;
	logic [CNT_W-1:0] cnt_reg; // Phase timer
	logic [4:0] bits_reg; // Bits still to send
	logic [SPLIT_W-1:0] frame_reg; // Outgoing bits, top first
	logic [CODE_W-1:0] code_reg; // Control fields
	logic [SEL_W-1:0] sel_reg;
	logic range_reg;
	logic defer_reg; // Update strobe rests high
	logic split_reg; // Two eight-bit bursts
	logic sclk_reg;
	logic data_reg;
	logic xfer_reg;
	logic upd_reg;
	logic wb_hit; // New request this cycle
	logic wr_hit;
	logic send_req;
	logic update_req;
	logic busy;

	// One answer per request; ack drops the cycle after
	assign wb_hit = CYC_I && STB_I && !ACK_O;
	assign wr_hit = wb_hit && WE_I;
	assign send_req = wr_hit && (ADR_I == COMMAND_OFS) && SEL_I[0] && DAT_I[CMD_SEND_POS];
	assign update_req = wr_hit && (ADR_I == COMMAND_OFS) && SEL_I[0] && DAT_I[CMD_UPDATE_POS];
	assign busy = (state_reg != ST_IDLE);

	// Bus acknowledge
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			ACK_O <= 1'b0;
		end
		else
		begin
			ACK_O <= wb_hit;
		end
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			DAT_O <= 32'h00000000;
		end
		else if (wb_hit && !WE_I)
		begin
			DAT_O <= 32'h00000000;
			case (ADR_I)
				CONTROL_OFS:
				begin
					DAT_O[CTL_CODE_LSB +: CODE_W] <= code_reg;
					DAT_O[CTL_SEL_LSB +: SEL_W] <= sel_reg;
					DAT_O[CTL_RANGE_POS] <= range_reg;
					DAT_O[CTL_DEFER_POS] <= defer_reg;
					DAT_O[CTL_SPLIT_POS] <= split_reg;
				end
				STATUS_OFS:
				begin
					DAT_O[STS_BUSY_POS] <= busy;
					DAT_O[STS_XFER_POS] <= xfer_reg;
					DAT_O[STS_UPD_POS] <= upd_reg;
				end
				default:
				begin
					DAT_O <= 32'h00000000;
				end
			endcase
		end
	end

	// Control register, one byte lane per field group
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			code_reg <= CODE_RESET;
			sel_reg <= CH_A;
			range_reg <= 1'b0;
			defer_reg <= 1'b0;
			split_reg <= 1'b0;
		end
		else if (wr_hit && (ADR_I == CONTROL_OFS))
		begin
			if (SEL_I[0])
			begin
				code_reg <= DAT_I[CTL_CODE_LSB +: CODE_W];
			end
			if (SEL_I[1])
			begin
				sel_reg <= DAT_I[CTL_SEL_LSB +: SEL_W]; // (R9)
				range_reg <= DAT_I[CTL_RANGE_POS]; // (R10)
			end
			if (SEL_I[2])
			begin
				defer_reg <= DAT_I[CTL_DEFER_POS];
				split_reg <= DAT_I[CTL_SPLIT_POS];
			end
		end
	end

	// Link sequencer. Commands arriving while busy are dropped;
	// software polls the busy flag rather than queueing.
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			bits_reg <= '0;
			frame_reg <= '0;
			sclk_reg <= 1'b1;
			data_reg <= 1'b0;
			xfer_reg <= 1'b1;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					cnt_reg <= '0;
					if (send_req)
					begin
						// Word in wire order, padded in front when split
						if (split_reg) // (R13)
						begin
							frame_reg <= {5'h00, sel_reg, range_reg, code_reg}; // (R14)
							bits_reg <= 5'(SPLIT_W);
						end
						else
						begin
							frame_reg <= {sel_reg, range_reg, code_reg, 5'h00}; // (R2) (R14)
							bits_reg <= 5'(WORD_W);
						end
						state_reg <= ST_HIGH;
					end
					else if (update_req)
					begin
						// Update pulse is only started from idle
						state_reg <= ST_UPDATE;
					end
				end
				ST_HIGH:
				begin
					// Bit set one clock after the rising edge, HALF_CYC - 1 clocks of setup
					data_reg <= frame_reg[SPLIT_W-1]; // (R3)
					if (cnt_reg == CNT_W'(HALF_CYC - 1)) // (R15)
					begin
						cnt_reg <= '0;
						sclk_reg <= 1'b0; // (R1)
						frame_reg <= {frame_reg[SPLIT_W-2:0], 1'b0};
						state_reg <= ST_LOW;
					end
					else
					begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				ST_LOW:
				begin
					if (cnt_reg == CNT_W'(HALF_CYC - 1)) // (R15)
					begin
						cnt_reg <= '0;
						sclk_reg <= 1'b1;
						bits_reg <= bits_reg - 1'b1;
						if (bits_reg == 5'h01)
						begin
							xfer_reg <= 1'b0; // (R4)
							state_reg <= ST_LOAD;
						end
						else if (split_reg && (bits_reg == 5'(BURST_W + 1))) // (R13)
						begin
							state_reg <= ST_GAP;
						end
						else
						begin
							state_reg <= ST_HIGH;
						end
					end
					else
					begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				ST_GAP:
				begin
					// Pause between bursts, strobe stays high
					if (cnt_reg == CNT_W'(HALF_CYC - 1))
					begin
						cnt_reg <= '0;
						state_reg <= ST_HIGH;
					end
					else
					begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				ST_LOAD:
				begin
					if (cnt_reg == CNT_W'(STROBE_CYC - 1)) // (R15)
					begin
						cnt_reg <= '0;
						xfer_reg <= 1'b1;
						state_reg <= ST_IDLE;
					end
					else
					begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				ST_UPDATE:
				begin
					// State held for the whole low pulse, or it would be cut short
					if (cnt_reg == CNT_W'(STROBE_CYC - 1)) // (R15)
					begin
						cnt_reg <= '0;
						state_reg <= ST_IDLE;
					end
					else
					begin
						cnt_reg <= cnt_reg + 1'b1;
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Update strobe rests at the defer level, pulses low on command
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			upd_reg <= 1'b0;
		end
		else
		begin
			upd_reg <= defer_reg && !(state_reg == ST_IDLE && !send_req && update_req)
				&& !(state_reg == ST_UPDATE && cnt_reg != CNT_W'(STROBE_CYC - 1)); // (R7) (R8)
		end
	end

	// Link wires straight from flops
	assign LINK.serial_clk = sclk_reg;
	assign LINK.serial_data = data_reg;
	assign LINK.transfer_strobe = xfer_reg;
	assign LINK.update_strobe = upd_reg;
endmodule

// [common/dac_link_pkg.sv]
/*
 Shared constants for the quad converter serial loader and its host
 controller: command word layout, link timing, host register map.
 Assumes a 50 MHz system clock on the host side.
*/
package dac_link_pkg;
	// Channel and code geometry
	localparam int CHANNELS = 4;
	localparam int CODE_W = 8;
	localparam int SEL_W = 2;
	localparam int LEVEL_W = CODE_W + 1;
	localparam int WORD_W = 11;
	localparam int SPLIT_W = 16;
	localparam int BURST_W = 8;
	// Command word field positions, shift register order
	localparam int SEL_HI_POS = 10;
	localparam int SEL_LO_POS = 9;
	localparam int RANGE_POS = 8;
	localparam int CODE_MSB_POS = 7;
	// Channel select codes
	localparam logic [1:0] CH_A = 2'h0;
	localparam logic [1:0] CH_B = 2'h1;
	localparam logic [1:0] CH_C = 2'h2;
	localparam logic [1:0] CH_D = 2'h3;
	// Reset values
	localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
	// Link timing, figures in ns, counts in host clocks
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCLK_MIN_PERIOD_NS = 1000;
	localparam int STROBE_MIN_LOW_NS = 250;
	localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_LOW_CYC = (STROBE_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host register byte offsets
	localparam logic [3:0] CONTROL_OFS = 4'h0;
	localparam logic [3:0] COMMAND_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	// Control register fields
	localparam int CTL_CODE_LSB = 0;
	localparam int CTL_SEL_LSB = 8;
	localparam int CTL_RANGE_POS = 10;
	localparam int CTL_DEFER_POS = 16;
	localparam int CTL_SPLIT_POS = 17;
	// Command register fields
	localparam int CMD_SEND_POS = 0;
	localparam int CMD_UPDATE_POS = 1;
	// Status register fields
	localparam int STS_BUSY_POS = 0;
	localparam int STS_XFER_POS = 1;
	localparam int STS_UPD_POS = 2;
endpackage

// [common/serial_link_if.sv]
/*
 Three-wire serial link plus update strobe between host and converter.
 Assumes the host end drives every wire; the device only listens.
*/
`timescale 1ns/1ns
interface serial_link_if;
	logic serial_clk; // Link clock, idles high
	logic serial_data; // Command bit, sampled on falling clock
	logic transfer_strobe; // High while shifting, low pulse loads
	logic update_strobe; // Low pulse or low level updates outputs
	// Host drives the link
	modport host
	(
		output serial_clk,
		output serial_data,
		output transfer_strobe,
		output update_strobe
	);
	// Converter listens
	modport device
	(
		input serial_clk,
		input serial_data,
		input transfer_strobe,
		input update_strobe
	);
endinterface

// [hdl/quad_dac_serial_loader.sv]
/*
 Converter end: serial shift register on the link clock, double
 buffered code latches per channel on the local clock.
 Assumes a free-running local clock well above the link rate and a
 power-on reset pulse on RESET_I. Strobe edges reach the latches
 two to three local clocks after they fall on the link.
*/
// Contract
// (R1) Shift data on falling clock while strobe high
// (R2) Command word is eleven bits long
// (R3) Most significant bit travels first
// (R4) Strobe low loads selected channel holding latch
// (R5) Update low: strobe also loads output latch
// (R6) Update high: loading leaves outputs unchanged
// (R7) Held value reaches output on update pulse
// (R8) Update falling copies all channels together
// (R9) Select 00..11 picks channel A..D
// (R10) Range bit chooses single or double gain
// (R11) Output equals code over 256 times gain
// (R12) Power-up clears every channel code
// (R13) Accept two eight-bit bursts or one
// (R14) Order select, range, code; last eleven count
// (R15) Host keeps clock and strobe timing limits
`timescale 1ns/1ns
module quad_dac_serial_loader
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	serial_link_if.device LINK,
	output logic [dac_link_pkg::LEVEL_W-1:0] CHANNEL_A_OUT_O,
	output logic [dac_link_pkg::LEVEL_W-1:0] CHANNEL_B_OUT_O,
	output logic [dac_link_pkg::LEVEL_W-1:0] CHANNEL_C_OUT_O,
	output logic [dac_link_pkg::LEVEL_W-1:0] CHANNEL_D_OUT_O,
	output logic [dac_link_pkg::CHANNELS-1:0] RANGE_BIT_O
);
	import dac_link_pkg::*;

	// Link domain shift register, newest bit at the bottom
	// Cleared only by reset; a cut frame leaves its bits behind
	logic [WORD_W-1:0] shift_reg;
	// Strobe synchronisers, first stage read only by second
	logic load_meta_reg;
	logic load_sync_reg;
	logic load_last_reg;
	logic upd_meta_reg;
	logic upd_sync_reg;
	logic upd_last_reg;
	// Edge events in the local domain
	logic load_fall;
	logic upd_fall;
	// Decoded command word fields
	// Slices follow wire order: select, range, then code
	logic [SEL_W-1:0] word_sel;
	logic word_range;
	logic [CODE_W-1:0] word_code;
	// Holding latches, one per channel
	logic [CODE_W-1:0] hold_code_reg [CHANNELS];
	logic hold_range_reg [CHANNELS];
	// Output latches, kept as scaled levels
	logic [LEVEL_W-1:0] out_level_reg [CHANNELS];
	logic out_range_reg [CHANNELS];

	// Level in units of one 256th of the reference
	// Range one doubles the level, so a ninth bit carries it;
	// full code at double gain reads as 510 steps.
	function automatic logic [LEVEL_W-1:0] scale
	(
		input logic [CODE_W-1:0] code,
		input logic range_bit
	);
		if (range_bit)
		begin
			scale = {code, 1'b0}; // (R10) (R11)
		end
		else
		begin
			scale = {1'b0, code}; // (R10) (R11)
		end
	endfunction

	// Shift on each falling link edge while the strobe is high.
	// Extra leading bits simply fall off the top, so a padded
	// sixteen-bit frame in two bursts lands the same as eleven.
	// Frame length is not counted here; the strobe alone ends it.
	always_ff @(negedge LINK.serial_clk or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			shift_reg <= '0;
		end
		else if (LINK.transfer_strobe) // (R1)
		begin
			shift_reg <= {shift_reg[WORD_W-2:0], LINK.serial_data}; // (R3) (R13) (R14)
		end
	end

	// Transfer strobe into the local domain
	// Resets high, the idle level of the strobe, so leaving reset
	// never shows a false load.
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			load_meta_reg <= 1'b1;
			load_sync_reg <= 1'b1;
			load_last_reg <= 1'b1;
		end
		else
		begin
			load_meta_reg <= LINK.transfer_strobe;
			load_sync_reg <= load_meta_reg;
			load_last_reg <= load_sync_reg;
		end
	end

	// Update strobe into the local domain
	// Resets low: a host holding the pin low after reset would
	// otherwise show a false fall and copy the holding latches.
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			upd_meta_reg <= 1'b0;
			upd_sync_reg <= 1'b0;
			upd_last_reg <= 1'b0;
		end
		else
		begin
			upd_meta_reg <= LINK.update_strobe;
			upd_sync_reg <= upd_meta_reg;
			upd_last_reg <= upd_sync_reg;
		end
	end

	// Falling edges seen after synchronisation
	// Taken from the second and third stage only; the first stage
	// may still be settling and is never read here.
	assign load_fall = load_last_reg && !load_sync_reg; // (R4)
	assign upd_fall = upd_last_reg && !upd_sync_reg; // (R8)

	// The word is read across domains without its own synchroniser.
	// It is safe because the link clock is idle while the strobe is
	// low, and the strobe edge arrives two local clocks late anyway.
	// Limitation: a host that clocks the next frame before the load edge reaches the latches
	// could tear the word read here.
	assign word_sel = shift_reg[SEL_HI_POS:SEL_LO_POS]; // (R2) (R14)
	assign word_range = shift_reg[RANGE_POS]; // (R2) (R14)
	assign word_code = shift_reg[CODE_MSB_POS:0]; // (R2) (R14)

	// Per channel latch pair
	// Channels are alike but for the address match
	generate
		for (genvar g = 0; g < CHANNELS; g++)
		begin : gen_channel
			logic hit;
			// Channel addressed by the current word
			// Raw slice compare; only acted on at a load edge
			assign hit = (word_sel == SEL_W'(g)); // (R9)

			// Holding latch takes the word on the strobe
			// Every load lands here whatever the update level, so a later
			// update pulse always carries the newest word.
			always_ff @(posedge CLK_I or posedge RESET_I)
			begin
				if (RESET_I)
				begin
					hold_code_reg[g] <= CODE_RESET; // (R12)
					hold_range_reg[g] <= 1'b0;
				end
				else if (load_fall && hit) // (R4)
				begin
					hold_code_reg[g] <= word_code;
					hold_range_reg[g] <= word_range;
				end
			end

			// Output latch. A strobe landing with the update edge
			// goes straight through, so the newest word is never lost.
			// Other channels still copy their holding latch on that edge.
			always_ff @(posedge CLK_I or posedge RESET_I)
			begin
				if (RESET_I)
				begin
					out_level_reg[g] <= {1'b0, CODE_RESET}; // (R12)
					out_range_reg[g] <= 1'b0;
				end
				else if (load_fall && hit && !upd_sync_reg) // (R5) (R6)
				begin
					out_level_reg[g] <= scale(word_code, word_range);
					out_range_reg[g] <= word_range;
				end
				else if (upd_fall) // (R7) (R8)
				begin
					out_level_reg[g] <= scale(hold_code_reg[g], hold_range_reg[g]);
					out_range_reg[g] <= hold_range_reg[g];
				end
			end

			// Gain setting straight from the latch
			assign RANGE_BIT_O[g] = out_range_reg[g]; // (R10)
		end
	endgenerate

	// Channel levels straight from the output latches
	// Fixed order A to D; RANGE_BIT_O bit g follows channel g
	assign CHANNEL_A_OUT_O = out_level_reg[CH_A]; // (R9)
	assign CHANNEL_B_OUT_O = out_level_reg[CH_B];
	assign CHANNEL_C_OUT_O = out_level_reg[CH_C];
	assign CHANNEL_D_OUT_O = out_level_reg[CH_D];
endmodule

// [verif/quad_dac_link_asserts.sv]
/*
 Checker for the serial link between host controller and converter.
 Assumes plain link signals sampled on the host clock, host parameters.
*/
`timescale 1ns/1ns
module quad_dac_link_asserts
#(
	parameter int HALF_CYC = 25,
	parameter int STROBE_CYC = 13
)
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic transfer_strobe,
	input wire logic update_strobe
);
	logic sclk_q; // Last link clock sample
	int run_cnt; // Samples of current clock level
	int bit_cnt; // Falling edges in this frame
	int load_cnt; // Samples with load strobe low
	int upd_cnt; // Samples with update strobe low
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	// Level run length of the link clock
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			sclk_q <= 1'b1;
			run_cnt <= 0;
		end
		else
		begin
			sclk_q <= serial_clk;
			run_cnt <= (serial_clk == sclk_q) ? run_cnt + 1 : 1;
		end
	end
	// Bits in the frame; cleared while loading
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
			bit_cnt <= 0;
		else if (!transfer_strobe)
			bit_cnt <= 0;
		else if (sclk_q && !serial_clk)
			bit_cnt <= bit_cnt + 1;
	end
	// Low runs of both strobes; reset counts as long, so no false alarm
	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			load_cnt <= STROBE_CYC;
			upd_cnt <= STROBE_CYC;
		end
		else
		begin
			load_cnt <= transfer_strobe ? 0 : load_cnt + 1;
			upd_cnt <= update_strobe ? 0 : upd_cnt + 1;
		end
	end
	property p_shift_gated;
		$fell(serial_clk) |-> transfer_strobe;
	endproperty
	a_shift_gated: assert property (p_shift_gated)
		else $error("link clock fell outside a frame");
	property p_data_stable;
		$fell(serial_clk) |-> $stable(serial_data);
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data moved at the sampling edge");
	property p_idle_clk;
		!transfer_strobe |-> serial_clk;
	endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("link clock low during load");
	property p_word_len;
		$fell(transfer_strobe) |-> (bit_cnt == 11 || bit_cnt == 16);
	endproperty
	a_word_len: assert property (p_word_len)
		else $error("frame length wrong");
	property p_half_period;
		(serial_clk != sclk_q) && transfer_strobe |-> run_cnt >= HALF_CYC;
	endproperty
	a_half_period: assert property (p_half_period)
		else $error("link clock phase too short");
	property p_load_low;
		$rose(transfer_strobe) |-> load_cnt >= STROBE_CYC;
	endproperty
	a_load_low: assert property (p_load_low)
		else $error("load pulse too short");
	property p_upd_low;
		$rose(update_strobe) |-> upd_cnt >= STROBE_CYC;
	endproperty
	a_upd_low: assert property (p_upd_low)
		else $error("update pulse too short");
	property p_upd_setup;
		$fell(update_strobe) |-> transfer_strobe;
	endproperty
	a_upd_setup: assert property (p_upd_setup)
		else $error("update fell during load");
endmodule

// [verif/testbench.sv]
/*
 Testbench: host controller and converter joined by the link.
 Assumes a 50 MHz host clock and an 80 ns converter clock whose edges sit on host falling edges.
*/
`timescale 1ns/1ns
module testbench;
	import dac_link_pkg::*;
	logic clk = 1'b0; // Host clock
	logic dclk = 1'b0; // Converter clock
	logic rst = 1'b1; // Shared reset
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'h0;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic [31:0] rdat;
	logic ack;
	logic [LEVEL_W-1:0] lvl [CHANNELS]; // Seen levels
	logic [CHANNELS-1:0] rbits;
	int n_mismatch = 0;
	int check_count = 0;
	int seed = 32'h771B28A1;
	logic mon_on = 1'b0; // Monitors armed after reset
	logic dfr_now = 1'b0; // Defer level last written
	logic [39:0] obs_last;
	logic [39:0] prev_v = 40'h0;
	logic [39:0] out_q [$]; // Expected output vectors
	logic [10:0] wire_q [$]; // Expected words on the wire
	logic [10:0] shift_sh;
	logic [8:0] exp_lvl [4] = '{default: 9'h0};
	logic [8:0] hold_lvl [4] = '{default: 9'h0};
	logic [3:0] exp_rb = 4'h0;
	logic [3:0] hold_rb = 4'h0;
	wire logic [39:0] obs = {lvl[0], lvl[1], lvl[2], lvl[3], rbits};
	serial_link_if link ();
	quad_dac_host_ctrl #(.HALF_CYC(SCLK_HALF_CYC), .STROBE_CYC(STROBE_LOW_CYC)) quad_dac_host_ctrl_i (.CLK_I(clk),
		.RESET_I(rst), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb),
		.DAT_O(rdat), .ACK_O(ack), .LINK(link.host));
	quad_dac_serial_loader quad_dac_serial_loader_i (.CLK_I(dclk), .RESET_I(rst), .LINK(link.device),
		.CHANNEL_A_OUT_O(lvl[0]), .CHANNEL_B_OUT_O(lvl[1]), .CHANNEL_C_OUT_O(lvl[2]),
		.CHANNEL_D_OUT_O(lvl[3]), .RANGE_BIT_O(rbits));
	quad_dac_link_asserts #(.HALF_CYC(SCLK_HALF_CYC), .STROBE_CYC(STROBE_LOW_CYC)) quad_dac_link_asserts_i
		(.CLK_I(clk), .RESET_I(rst), .serial_clk(link.serial_clk), .serial_data(link.serial_data),
		.transfer_strobe(link.transfer_strobe), .update_strobe(link.update_strobe));
	// Host clock
	always #10 clk = ~clk;
	// Converter clock; its edges fall on host falling edges, never on rising ones
	always #40 dclk = ~dclk;
	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Classic single Wishbone cycle; the wait is bounded
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			n_mismatch++;
			results();
		end
	endtask
	// Poll status until the sequencer is idle
	task automatic wait_idle();
		logic [31:0] q;
		int n;
		n = 0;
		do
		begin
			wb(1'b0, STATUS_OFS, 32'h0, q);
			n++;
		end
		while (q[STS_BUSY_POS] !== 1'b0 && n < 1000);
		if (q[STS_BUSY_POS] !== 1'b0)
		begin
			n_mismatch++;
			results();
		end
	endtask
	// Queue a note only when the outputs should move
	task automatic note_out();
		logic [39:0] v;
		v = {exp_lvl[0], exp_lvl[1], exp_lvl[2], exp_lvl[3], exp_rb};
		if (v !== prev_v)
			out_q.push_back(v);
		prev_v = v;
	endtask
	task automatic send(input logic [1:0] ch, input logic [7:0] code, input logic range_bit, input logic dfr,
		input logic spl);
		logic [31:0] q;
		// Dropping defer copies every holding latch
		if (dfr_now && !dfr)
		begin
			exp_lvl = hold_lvl;
			exp_rb = hold_rb;
			note_out();
		end
		dfr_now = dfr;
		hold_lvl[ch] = {1'b0, code} << range_bit;
		hold_rb[ch] = range_bit;
		if (!dfr)
		begin
			exp_lvl[ch] = hold_lvl[ch];
			exp_rb[ch] = range_bit;
		end
		note_out();
		wire_q.push_back({ch, range_bit, code});
		wb(1'b1, CONTROL_OFS, {14'h0, spl, dfr, 5'h0, range_bit, ch, code}, q);
		wb(1'b1, COMMAND_OFS, 32'h1, q);
		wait_idle();
	endtask
	task automatic update();
		logic [31:0] q;
		exp_lvl = hold_lvl;
		exp_rb = hold_rb;
		note_out();
		wb(1'b1, COMMAND_OFS, 32'h2, q);
		wait_idle();
	endtask
	// Bits as the converter shifts them
	always @(negedge link.serial_clk)
		if (link.transfer_strobe === 1'b1)
			shift_sh = {shift_sh[9:0], link.serial_data};
	// Last eleven bits on each load pulse
	always @(negedge link.transfer_strobe)
		if (mon_on)
			check("wire word", wire_q.size() ? wire_q.pop_front() : 'x, shift_sh);
	// Every output change takes the oldest note
	always @(posedge clk)
		if (mon_on && obs !== obs_last)
		begin
			obs_last = obs;
			check("channel outputs", out_q.size() ? out_q.pop_front() : 'x, obs);
		end
	initial
	begin
		logic [31:0] q;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset outputs", 40'h0, obs);
		obs_last = obs;
		mon_on = 1'b1;
		$display("test reset done");
		// All channels, both ranges, both framings
		for (int i = 0; i < 8; i++)
			send(i[1:0], 8'($random(seed)), i[2], 1'b0, i[0]);
		send(CH_D, 8'hFF, 1'b1, 1'b0, 1'b0);
		$display("test immediate done");
		// Held loads, then one update pulse
		send(CH_B, 8'h5A, 1'b0, 1'b1, 1'b0);
		send(CH_C, 8'hA5, 1'b1, 1'b1, 1'b1);
		update();
		$display("test deferred done");
		// Clearing defer also releases held values
		send(CH_A, 8'h01, 1'b1, 1'b1, 1'b0);
		send(CH_D, 8'h80, 1'b0, 1'b0, 1'b0);
		$display("test defer clear done");
		wb(1'b0, CONTROL_OFS, 32'h0, q);
		check("control readback", {8'h0, 14'h0, 2'b00, 5'h0, 1'b0, CH_D, 8'h80}, {8'h0, q});
		wb(1'b0, 4'hC, 32'h0, q);
		check("unmapped read", 40'h0, {8'h0, q});
		repeat (40) @(posedge clk);
		check("pending notes", 40'h0, 40'(out_q.size() + wire_q.size()));
		$display("test bus done");
		results();
	end
endmodule
